/* core/sbrg_pkg.sv */
/*
 * Constants shared by the serial host bit-rate generator and framer.
 * Assumes a 200 MHz system clock and a 27.12 MHz bit-rate reference derived from it.
 */
package sbrg_pkg;

	// ****************************************************************
	// Clock and reference figures
	// ****************************************************************
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned CLK_KHZ       = 1000000 / CLK_PERIOD_NS;
	localparam int unsigned REF_KHZ       = 27120;
	localparam int unsigned ACC_W         = 18;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] ADDR_RATE_CFG = 8'h3B;
	localparam logic [7:0] ADDR_STATUS   = 8'hF0;
	localparam logic [7:0] RATE_CFG_RST  = 8'h7A;

	localparam int unsigned EXP_LSB = 5;
	localparam int unsigned EXP_W   = 3;
	localparam int unsigned DIV_LSB = 0;
	localparam int unsigned DIV_W   = 5;

	localparam int unsigned ST_TX_BUSY   = 0;
	localparam int unsigned ST_RX_BUSY   = 1;
	localparam int unsigned ST_PENDING   = 2;
	localparam int unsigned ST_FRAME_ERR = 3;

	// ****************************************************************
	// Rate formula and framing
	// ****************************************************************
	localparam int unsigned         BITDIV_W     = 13;
	localparam logic [BITDIV_W-1:0] DIV_ADD_LOW  = 13'h0001;
	localparam logic [BITDIV_W-1:0] DIV_ADD_HIGH = 13'h0021;
	localparam int unsigned         DATA_BITS    = 8;

	typedef enum logic [1:0] {SBRG_IDLE, SBRG_START, SBRG_DATA, SBRG_STOP} sbrg_state_t;

endpackage

/* core/sbrg_ref_tick.sv */
/*
 * Fractional divider that turns the system clock into a one-cycle tick at the reference rate.
 * Assumes the reference rate is below the system clock rate.
 */
`timescale 1ns/100ps

module sbrg_ref_tick
(
	input  wire logic clk,
	input  wire logic reset_n,
	output logic      ref_tick
);

	localparam logic [sbrg_pkg::ACC_W-1:0] STEP = sbrg_pkg::ACC_W'(sbrg_pkg::REF_KHZ);
	localparam logic [sbrg_pkg::ACC_W-1:0] WRAP = sbrg_pkg::ACC_W'(sbrg_pkg::CLK_KHZ);

	logic [sbrg_pkg::ACC_W-1:0] acc_r;
	logic [sbrg_pkg::ACC_W:0]   acc_sum;
	logic                       wraps;

	// The tick spacing jitters by one system cycle; the long-run mean is exact.
	assign acc_sum = {1'b0, acc_r} + {1'b0, STEP};
	assign wraps   = acc_sum >= {1'b0, WRAP};

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			acc_r <= '0;
		else if (wraps)
			acc_r <= sbrg_pkg::ACC_W'(acc_sum - {1'b0, WRAP});
		else
			acc_r <= acc_sum[sbrg_pkg::ACC_W-1:0];
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ref_tick <= 1'b0;
		else
			ref_tick <= wraps;
	end

endmodule // sbrg_ref_tick

/* core/sbrg_top.sv */
/*
 * Bit-rate generator and 8N1 character framer for the asynchronous serial host link.
 * Assumes serial_rxd and the register port are synchronous to clk.
 */
`timescale 1ns/100ps

module sbrg_top
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	output logic      [7:0] rx_data,
	output logic            rx_valid,
	output logic            serial_txd,
	input  wire logic       serial_rxd
);

	localparam int unsigned DW = sbrg_pkg::BITDIV_W;

	// ****************************************************************
	// Register port
	// ****************************************************************
	logic [7:0]    serial_bit_rate_config_r;
	logic [7:0]    rate_act_r;
	logic          frame_err_r;
	logic          frame_err_set;
	logic          tx_busy;
	logic          rx_busy;
	logic          sel_rate;
	logic          sel_status;
	logic [7:0]    status_word;
	logic [7:0]    read_mux;

	assign sel_rate   = reg_addr == sbrg_pkg::ADDR_RATE_CFG;
	assign sel_status = reg_addr == sbrg_pkg::ADDR_STATUS;

	assign status_word = {4'h0, frame_err_r, (serial_bit_rate_config_r != rate_act_r), rx_busy, tx_busy};
	assign read_mux    = sel_rate ? serial_bit_rate_config_r : (sel_status ? status_word : 8'h00);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			serial_bit_rate_config_r <= sbrg_pkg::RATE_CFG_RST;
		else if (reg_wr && sel_rate)
			serial_bit_rate_config_r <= reg_wdata;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= reg_rd ? read_mux : 8'h00;
	end

	// A framing error that lands in the clearing cycle survives the clear.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			frame_err_r <= 1'b0;
		else if (frame_err_set)
			frame_err_r <= 1'b1;
		else if (reg_wr && sel_status && reg_wdata[sbrg_pkg::ST_FRAME_ERR])
			frame_err_r <= 1'b0;
	end

	// ****************************************************************
	// Active rate and bit divisor
	// ****************************************************************
	logic [2:0]    exp_f;
	logic [4:0]    div_f;
	logic [DW-1:0] div_base;
	logic [DW-1:0] bit_div;
	logic [DW-1:0] half_div;
	logic          ref_tick;

	// Both directions share one rate, so the copy only moves when both are quiet.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rate_act_r <= sbrg_pkg::RATE_CFG_RST;
		else if (!tx_busy && !rx_busy)
			rate_act_r <= serial_bit_rate_config_r;
	end

	assign exp_f    = rate_act_r[sbrg_pkg::EXP_LSB +: sbrg_pkg::EXP_W];
	assign div_f    = rate_act_r[sbrg_pkg::DIV_LSB +: sbrg_pkg::DIV_W];
	assign div_base = {{(DW-5){1'b0}}, div_f} + ((exp_f == 3'h0) ? sbrg_pkg::DIV_ADD_LOW : sbrg_pkg::DIV_ADD_HIGH);
	assign bit_div  = (exp_f == 3'h0) ? div_base : DW'(div_base << (exp_f - 3'h1));
	assign half_div = {1'b0, bit_div[DW-1:1]};

	sbrg_ref_tick u_ref_tick
	(
		.clk      (clk),
		.reset_n  (reset_n),
		.ref_tick (ref_tick)
	);

	// ****************************************************************
	// Transmitter
	// ****************************************************************
	sbrg_pkg::sbrg_state_t tx_state_r;
	sbrg_pkg::sbrg_state_t tx_state_nxt;
	logic [DW-1:0] tx_cnt_r;
	logic [2:0]    tx_idx_r;
	logic [7:0]    tx_shift_r;
	logic          tx_bit_end;
	logic          tx_take;

	assign tx_busy    = tx_state_r != sbrg_pkg::SBRG_IDLE;
	assign tx_ready   = !tx_busy;
	assign tx_take    = tx_valid && tx_ready;
	assign tx_bit_end = tx_busy && ref_tick && (tx_cnt_r == bit_div - 1'b1);

	always_comb
	begin
		tx_state_nxt = tx_state_r;
		case (tx_state_r)
			sbrg_pkg::SBRG_IDLE:  if (tx_take) tx_state_nxt = sbrg_pkg::SBRG_START;
			sbrg_pkg::SBRG_START: if (tx_bit_end) tx_state_nxt = sbrg_pkg::SBRG_DATA;
			sbrg_pkg::SBRG_DATA:  if (tx_bit_end && tx_idx_r == 3'h7) tx_state_nxt = sbrg_pkg::SBRG_STOP;
			sbrg_pkg::SBRG_STOP:  if (tx_bit_end) tx_state_nxt = sbrg_pkg::SBRG_IDLE;
			default:              tx_state_nxt = sbrg_pkg::SBRG_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			tx_state_r <= sbrg_pkg::SBRG_IDLE;
		else
			tx_state_r <= tx_state_nxt;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			tx_cnt_r <= '0;
		else if (!tx_busy || tx_bit_end)
			tx_cnt_r <= '0;
		else if (ref_tick)
			tx_cnt_r <= tx_cnt_r + 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_idx_r   <= 3'h0;
			tx_shift_r <= 8'h00;
		end
		else if (tx_take)
		begin
			tx_idx_r   <= 3'h0;
			tx_shift_r <= tx_data;
		end
		else if (tx_bit_end && tx_state_r == sbrg_pkg::SBRG_DATA)
		begin
			tx_idx_r   <= tx_idx_r + 3'h1;
			tx_shift_r <= {1'b0, tx_shift_r[7:1]};
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			serial_txd <= 1'b1;
		else if (tx_state_nxt == sbrg_pkg::SBRG_START)
			serial_txd <= 1'b0;
		else if (tx_state_nxt == sbrg_pkg::SBRG_DATA)
			serial_txd <= (tx_bit_end && tx_state_r == sbrg_pkg::SBRG_DATA) ? tx_shift_r[1] : tx_shift_r[0];
		else
			serial_txd <= 1'b1;
	end

	// ****************************************************************
	// Receiver
	// ****************************************************************
	sbrg_pkg::sbrg_state_t rx_state_r;
	logic [DW-1:0] rx_cnt_r;
	logic [2:0]    rx_idx_r;
	logic [7:0]    rx_shift_r;
	logic          rx_prev_r;
	logic          rx_sample;
	logic          rx_begin;

	assign rx_busy   = rx_state_r != sbrg_pkg::SBRG_IDLE;
	assign rx_begin  = !rx_busy && rx_prev_r && !serial_rxd;
	// The start bit is checked in its middle, every later bit one full bit time on.
	assign rx_sample = rx_busy && ref_tick &&
		(rx_cnt_r == ((rx_state_r == sbrg_pkg::SBRG_START) ? half_div : bit_div - 1'b1));
	assign frame_err_set = rx_sample && rx_state_r == sbrg_pkg::SBRG_STOP && !serial_rxd;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rx_prev_r <= 1'b1;
		else
			rx_prev_r <= serial_rxd;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rx_cnt_r <= '0;
		else if (!rx_busy || rx_sample)
			rx_cnt_r <= '0;
		else if (ref_tick)
			rx_cnt_r <= rx_cnt_r + 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rx_state_r <= sbrg_pkg::SBRG_IDLE;
		else
		begin
			case (rx_state_r)
				sbrg_pkg::SBRG_IDLE:  if (rx_begin) rx_state_r <= sbrg_pkg::SBRG_START;
				sbrg_pkg::SBRG_START:
					if (rx_sample)
						rx_state_r <= serial_rxd ? sbrg_pkg::SBRG_IDLE : sbrg_pkg::SBRG_DATA;
				sbrg_pkg::SBRG_DATA:
					if (rx_sample && rx_idx_r == 3'h7)
						rx_state_r <= sbrg_pkg::SBRG_STOP;
				sbrg_pkg::SBRG_STOP:  if (rx_sample) rx_state_r <= sbrg_pkg::SBRG_IDLE;
				default:              rx_state_r <= sbrg_pkg::SBRG_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_idx_r   <= 3'h0;
			rx_shift_r <= 8'h00;
		end
		else if (rx_begin)
			rx_idx_r <= 3'h0;
		else if (rx_sample && rx_state_r == sbrg_pkg::SBRG_DATA)
		begin
			rx_idx_r   <= rx_idx_r + 3'h1;
			rx_shift_r <= {serial_rxd, rx_shift_r[7:1]};
		end
	end

	// A character with a broken stop bit is flagged and not delivered.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_data  <= 8'h00;
			rx_valid <= 1'b0;
		end
		else
		begin
			rx_valid <= rx_sample && rx_state_r == sbrg_pkg::SBRG_STOP && serial_rxd;
			if (rx_sample && rx_state_r == sbrg_pkg::SBRG_STOP && serial_rxd)
				rx_data <= rx_shift_r;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	logic          cfg_written_r;
	logic [DW+2:0] ref_seen_r;
	logic [3:0]    tx_bits_r;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			cfg_written_r <= 1'b0;
		else if (reg_wr && sel_rate)
			cfg_written_r <= 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ref_seen_r <= '0;
		else if (tx_take)
			ref_seen_r <= '0;
		else if (ref_tick && tx_busy)
			ref_seen_r <= ref_seen_r + 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			tx_bits_r <= 4'h0;
		else if (tx_take)
			tx_bits_r <= 4'h0;
		else if (tx_bit_end)
			tx_bits_r <= tx_bits_r + 4'h1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_reset_rate: assert property (!cfg_written_r |-> serial_bit_rate_config_r == 8'h7A)
		else $error("rate register lost its reset value");
	a_div_low: assert property (exp_f == 3'h0 |-> bit_div == {8'h00, div_f} + 13'h0001)
		else $error("low exponent divisor wrong");
	a_div_high: assert property (exp_f == 3'h3 |-> bit_div == ({8'h00, div_f} + 13'h0021) * 13'h0004)
		else $error("high exponent divisor wrong");
	a_bit_time: assert property (tx_bit_end |-> ref_seen_r == (DW+3)'(bit_div) * (DW+3)'(tx_bits_r + 4'h1) - 1'b1)
		else $error("bit time differs from divisor");
	a_start_bit: assert property (tx_take |=> !serial_txd && tx_busy)
		else $error("start bit not low");
	a_frame_ten: assert property (tx_busy ##1 !tx_busy |-> tx_bits_r == 4'hA && serial_txd)
		else $error("character not ten bits");
	a_rate_hold: assert property ((tx_busy || rx_busy) && $past(tx_busy || rx_busy) |-> $stable(rate_act_r))
		else $error("rate changed inside a character");
	a_txd_steady: assert property (!tx_bit_end && !tx_take |=> $stable(serial_txd))
		else $error("line moved mid bit");

	c_tx_char: cover property (tx_busy ##1 !tx_busy);
	c_rx_char: cover property (rx_valid);
	c_frame_err: cover property (frame_err_set);
	c_rate_switch: cover property ($changed(rate_act_r));

endmodule // sbrg_top

/* testbench/sbrg_host_model.sv */
/*
 * Host-side asynchronous serial port: receives the device's characters and sends characters to it.
 * Assumes the bench sets bit_ns to the programmed bit time before each frame.
 */
`timescale 1ns/100ps

module sbrg_host_model
(
	input  wire logic txd,
	output logic      rxd
);
	// ************
	// Receiver and sender
	// ************
	real        bit_ns = 8702.0;
	logic [7:0] got = 8'h00;
	logic       got_stop = 1'b0;
	int         n_got = 0;

	initial rxd = 1'b1;

	// Sampling in mid-bit tolerates the reference tick jitter of the device.
	always @(negedge txd)
	begin
		#(bit_ns * 1.5);
		for (int i = 0; i < 8; i++)
		begin
			got[i] = txd;
			#(bit_ns);
		end
		got_stop = txd;
		n_got++;
	end

	// The bench only ever hands rates at or below the supported ceiling.
	task automatic send(input logic [7:0] d, input logic stop);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			rxd <= f[i];
			#(bit_ns);
		end
		rxd <= 1'b1;
	endtask
endmodule // sbrg_host_model

/* testbench/tb_serial_host_baud_generator.sv */
/*
 * Self-checking bench for the bit-rate generator and character framer.
 * Assumes sbrg_top and the host model; clock 200 MHz.
 */
`timescale 1ns/100ps

module tb_serial_host_baud_generator;
	logic       clk = 1'b0;
	logic       reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [7:0] tx_data = 8'h00;
	logic       tx_valid = 1'b0;
	logic       tx_ready;
	logic [7:0] rx_data;
	logic       rx_valid;
	logic       serial_txd;
	logic       serial_rxd;
	int         fails = 0;
	int         n_compared = 0;
	real        t_rise = 0.0;
	real        cur_ns = 0.0;

	sbrg_top dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
		.serial_txd(serial_txd), .serial_rxd(serial_rxd));
	sbrg_host_model host (.txd(serial_txd), .rxd(serial_rxd));

	initial forever #2.5 clk = ~clk;
	always @(posedge serial_txd) t_rise = $realtime;

	// ************
	// Reporting and bus tasks
	// ************
	task automatic complete_run();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic fail(input string m);
		fails++;
		$display("[FAIL] %0t %s", $time, m);
	endtask

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
			fail($sformatf("got %h expected %h", got, exp));
	endtask

	// One reference tick of slack covers where the first bit starts against the tick train.
	task automatic check_time(input real got, input real exp);
		n_compared++;
		if (got < exp - 40.0 || got > exp + 40.0)
			fail($sformatf("span %0.1f ns expected %0.1f ns", got, exp));
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check8(reg_rdata, exp);
	endtask

	function automatic real bit_time(input logic [7:0] cfg);
		int n;
		n = (cfg[7:5] == 3'h0) ? int'(cfg[4:0]) + 1 : (int'(cfg[4:0]) + 33) << (int'(cfg[7:5]) - 1);
		return n * 1000.0 / 27.12;
	endfunction

	task automatic set_rate(input logic [7:0] cfg);
		reg_write(8'h3B, cfg);
		cur_ns = bit_time(cfg);
		host.bit_ns = cur_ns;
	endtask

	task automatic wait_ready();
		for (int i = 0; i < 40000; i++)
		begin
			@(posedge clk);
			#1;
			if (tx_ready === 1'b1)
				return;
		end
		fail("transmitter never idle");
		complete_run();
	endtask

	// Data must have bit 7 clear so the last rising edge is the start of the stop bit.
	task automatic send_char(input logic [7:0] d, input logic [7:0] late);
		real t0;
		int  k;
		k = host.n_got;
		wait_ready();
		@(posedge clk);
		tx_valid <= 1'b1;
		tx_data <= d;
		@(posedge clk);
		tx_valid <= 1'b0;
		t0 = $realtime;
		if (late != 8'h00)
		begin
			reg_write(8'h3B, late);
			check_reg(8'hF0, 8'h05);
		end
		for (int i = 0; i < 40000 && host.n_got == k; i++)
			@(posedge clk);
		if (host.n_got == k)
		begin
			fail("no character seen");
			complete_run();
		end
		check8(host.got, d);
		check8({7'h00, host.got_stop}, 8'h01);
		check_time(t_rise - t0, 9.0 * cur_ns);
	endtask

	task automatic recv_char(input logic [7:0] d, input logic stop);
		logic seen;
		seen = 1'b0;
		fork
			host.send(d, stop);
			for (int i = 0; i < int'(cur_ns * 2.2) && !seen; i++)
			begin
				@(posedge clk);
				#1;
				if (rx_valid === 1'b1)
					seen = 1'b1;
			end
		join
		check8({7'h00, seen}, {7'h00, stop});
		if (stop)
			check8(rx_data, d);
	endtask

	// ************
	// Scenarios
	// ************
	task automatic test_reset();
		check_reg(8'h3B, 8'h7A);
		check_reg(8'h55, 8'h00);
		check_reg(8'hF0, 8'h00);
		reg_write(8'h3B, 8'hC9);
		check_reg(8'h3B, 8'hC9);
	endtask

	task automatic test_rates();
		logic [7:0] cfg [4] = '{8'h7A, 8'h15, 8'h3A, 8'h1C};
		logic [7:0] dat [4] = '{8'h55, 8'h2A, 8'h13, 8'h6C};
		for (int i = 0; i < 4; i++)
		begin
			set_rate(cfg[i]);
			send_char(dat[i], 8'h00);
		end
	endtask

	task automatic test_receive();
		recv_char(8'hB4, 1'b1);
		recv_char(8'h3C, 1'b0);
		check_reg(8'hF0, 8'h08);
		reg_write(8'hF0, 8'h08);
		check_reg(8'hF0, 8'h00);
		set_rate(8'h3A);
		recv_char(8'hE1, 1'b1);
	endtask

	task automatic test_switch();
		set_rate(8'h15);
		send_char(8'h4D, 8'h3A);
		cur_ns = bit_time(8'h3A);
		host.bit_ns = cur_ns;
		send_char(8'h32, 8'h00);
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		test_reset();
		test_rates();
		test_receive();
		test_switch();
		complete_run();
	end
endmodule // tb_serial_host_baud_generator
